// ---- src/exec_unit_defs.vh ----
/*
 * constants for the instruction execution unit: register offsets, field
 * positions, opcodes, flag bits and reset values.
 * assumes it is included by bare name and holds definitions only.
 */
`ifndef EXEC_UNIT_DEFS_VH
`define EXEC_UNIT_DEFS_VH

// register byte offsets
`define OFS_EXEC 8'h00
`define OFS_WORK 8'h04
`define OFS_FLAGS 8'h08
`define OFS_PC 8'h0c
`define OFS_STACK 8'h10
`define OFS_MADDR 8'h14
`define OFS_MDATA 8'h18
`define OFS_WDOG 8'h1c

// exec register fields
`define EX_OP 4:0
`define EX_OPND 15:8
`define EX_TGT 27:16

// flag register bits
`define F_C 0
`define F_AC 1
`define F_Z 2
`define F_OV 3
`define F_SLEEP 4
`define F_TO 5
`define F_GATE 6
`define F_BUSY 7
`define FLAGS_RST 8'h00

`define PC_W 12
`define PC_RST 12'h000
`define IRQ_VECTOR 12'h004

// opcodes
`define OP_IDLE 5'h00
`define OP_INV_M 5'h01
`define OP_INV_W 5'h02
`define OP_DADJ 5'h03
`define OP_DEC_M 5'h04
`define OP_DEC_W 5'h05
`define OP_INC_M 5'h06
`define OP_INC_W 5'h07
`define OP_PDOWN 5'h08
`define OP_BRANCH 5'h09
`define OP_CP_MW 5'h0a
`define OP_CP_IW 5'h0b
`define OP_CP_WM 5'h0c
`define OP_OR_M 5'h0d
`define OP_OR_I 5'h0e
`define OP_OR_WB 5'h0f
`define OP_SUBX 5'h10
`define OP_SUBX_V 5'h11
`define OP_IRQX 5'h12
`define OP_RL_M 5'h13
`define OP_RL_W 5'h14
`define OP_RLC_M 5'h15
`define OP_RLC_W 5'h16
`define OP_RR_M 5'h17
`define OP_RR_W 5'h18
`define OP_RRC_M 5'h19
`define OP_RRC_W 5'h1a
`define OP_SBC_W 5'h1b
`define OP_SBC_M 5'h1c

`define BCD_MAX 4'h9
`define BCD_FIX 4'h6
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- src/data_ram.v ----
/*
 * data memory of the execution unit: one port, synchronous write,
 * registered read.
 * assumes one clock; read data follow the address by one edge.
 */
`timescale 1ns/1ps
module data_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,             // system clock
  input wire we_i,              // write enable
  input wire [AW-1:0] addr_i,   // byte address
  input wire [DW-1:0] wdata_i,  // write data
  output reg [DW-1:0] rdata_o   // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // read first: a write on the same edge returns the old contents
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule // data_ram

// ---- src/exec_unit.v ----
/*
 * instruction execution unit for an 8-bit core: runs one instruction per
 * software request, holding work_reg, flags, program counter, a one-deep
 * return stack and a watchdog counter; registers on AXI4-Lite.
 * assumes one 100 MHz clock, asynchronous active-low reset and an
 * asynchronous interrupt-pending pin.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module exec_unit #(
  parameter AW = 8,   // data memory address width
  parameter PRE_W = 8 // watchdog prescaler width
) (
  input wire sys_clk_i,             // system clock
  input wire rst_n_i,               // async reset, active low
  input wire irq_pending_i,         // interrupt pending, async pin
  input wire [7:0] s_axi_awaddr,    // write address
  input wire s_axi_awvalid,         // write address valid
  output reg s_axi_awready,         // write address ready
  input wire [31:0] s_axi_wdata,    // write data
  input wire [3:0] s_axi_wstrb,     // write byte strobes
  input wire s_axi_wvalid,          // write data valid
  output reg s_axi_wready,          // write data ready
  output reg [1:0] s_axi_bresp,     // write response
  output reg s_axi_bvalid,          // write response valid
  input wire s_axi_bready,          // write response ready
  input wire [7:0] s_axi_araddr,    // read address
  input wire s_axi_arvalid,         // read address valid
  output reg s_axi_arready,         // read address ready
  output reg [31:0] s_axi_rdata,    // read data
  output reg [1:0] s_axi_rresp,     // read response
  output reg s_axi_rvalid,          // read data valid
  input wire s_axi_rready,          // read data ready
  output reg halted_o,              // power-down, core clock stopped
  output reg irq_service_o          // pulse: pending interrupt vectored
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_EXEC = 3'd2;
  localparam S_DUMMY = 3'd3;
  localparam S_HALT = 3'd4;

  reg [2:0] state_r;
  reg busy_q_r;
  reg [4:0] op_r;
  reg [7:0] opnd_r;
  reg [`PC_W-1:0] tgt_r;
  reg [7:0] work_reg_r;
  reg [7:0] flags_r;
  reg [`PC_W-1:0] pc_r;
  reg [`PC_W-1:0] stack_r;
  reg [AW-1:0] maddr_r;
  reg [7:0] watchdog_counter_r;
  reg [PRE_W-1:0] pre_r;
  reg irq_s1_r;
  reg irq_s2_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] ar_addr_r;
  reg rd_pend_r;

  wire busy = (state_r == S_FETCH) || (state_r == S_EXEC) ||
              (state_r == S_DUMMY);
  wire do_wr = aw_got_r && w_got_r && !busy;
  wire do_rd = rd_pend_r && !busy && !busy_q_r;
  wire exec_go = do_wr && (aw_addr_r == `OFS_EXEC) && w_strb_r[0];
  wire [7:0] m_rd;
  wire [31:0] flags_rd = {24'h0, busy, flags_r[6:0]};

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge under write strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFS_EXEC) || (a == `OFS_WORK) ||
               (a == `OFS_FLAGS) || (a == `OFS_PC) ||
               (a == `OFS_STACK) || (a == `OFS_MADDR) ||
               (a == `OFS_MDATA) || (a == `OFS_WDOG);
    end
  endfunction

  // byte-merged register write values, cut to each register's width below
  wire [31:0] work_mg = merge({24'h0, work_reg_r}, w_data_r, w_strb_r);
  wire [31:0] flags_mg = merge(flags_rd, w_data_r, w_strb_r);
  wire [31:0] pc_mg = merge({20'h0, pc_r}, w_data_r, w_strb_r);
  wire [31:0] stack_mg = merge({20'h0, stack_r}, w_data_r, w_strb_r);

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  // subtract with borrow: carry set means no borrow
  wire nb = ~flags_r[`F_C];
  wire [8:0] sbc_full = {1'b0, work_reg_r} - {1'b0, m_rd} - {8'h00, nb};
  wire [4:0] sbc_low = {1'b0, work_reg_r[3:0]} - {1'b0, m_rd[3:0]} -
                       {4'h0, nb};
  wire sbc_ov = (work_reg_r[7] != m_rd[7]) &&
                (sbc_full[7] != work_reg_r[7]);

  // decimal adjust corrections judged on the original nibbles
  wire dadj_lo = (work_reg_r[3:0] > `BCD_MAX) ||
                 flags_r[`F_AC];
  wire dadj_hi = (work_reg_r[7:4] > `BCD_MAX) ||
                 flags_r[`F_C];
  wire [7:0] dadj_add = {dadj_hi ? `BCD_FIX : 4'h0,
                         dadj_lo ? `BCD_FIX : 4'h0};
  wire [8:0] dadj_sum = {1'b0, work_reg_r} + {1'b0, dadj_add};

  reg [7:0] res;
  reg to_mem;
  reg to_work;
  reg upd_z;
  reg new_c;
  reg upd_c;

  // result, destination and flag selection per opcode
  always @* begin
    res = 8'h00;
    to_mem = 1'b0;
    to_work = 1'b0;
    upd_z = 1'b0;
    new_c = flags_r[`F_C];
    upd_c = 1'b0;
    case (op_r)
      `OP_INV_M, `OP_INV_W: begin
        res = ~m_rd;
        to_mem = (op_r == `OP_INV_M);
        to_work = (op_r == `OP_INV_W);
        upd_z = 1'b1;
      end
      `OP_DADJ: begin
        res = dadj_sum[7:0];
        to_mem = 1'b1;
        new_c = flags_r[`F_C] | dadj_sum[8];
        upd_c = 1'b1;
      end
      `OP_DEC_M, `OP_DEC_W: begin
        res = m_rd - 8'h01;
        to_mem = (op_r == `OP_DEC_M);
        to_work = (op_r == `OP_DEC_W);
        upd_z = 1'b1;
      end
      `OP_INC_M, `OP_INC_W: begin
        res = m_rd + 8'h01;
        to_mem = (op_r == `OP_INC_M);
        to_work = (op_r == `OP_INC_W);
        upd_z = 1'b1;
      end
      `OP_CP_MW: begin
        res = m_rd;
        to_work = 1'b1;
      end
      `OP_CP_IW, `OP_SUBX_V: begin
        res = opnd_r;
        to_work = 1'b1;
      end
      `OP_CP_WM: begin
        res = work_reg_r;
        to_mem = 1'b1;
      end
      `OP_OR_M, `OP_OR_WB: begin
        res = work_reg_r | m_rd;
        to_mem = (op_r == `OP_OR_WB);
        to_work = (op_r == `OP_OR_M);
        upd_z = 1'b1;
      end
      `OP_OR_I: begin
        res = work_reg_r | opnd_r;
        to_work = 1'b1;
        upd_z = 1'b1;
      end
      `OP_RL_M, `OP_RL_W: begin
        res = {m_rd[6:0], m_rd[7]};
        to_mem = (op_r == `OP_RL_M);
        to_work = (op_r == `OP_RL_W);
      end
      `OP_RLC_M, `OP_RLC_W: begin
        res = {m_rd[6:0], flags_r[`F_C]};
        new_c = m_rd[7];
        upd_c = 1'b1;
        to_mem = (op_r == `OP_RLC_M);
        to_work = (op_r == `OP_RLC_W);
      end
      `OP_RR_M, `OP_RR_W: begin
        res = {m_rd[0], m_rd[7:1]};
        to_mem = (op_r == `OP_RR_M);
        to_work = (op_r == `OP_RR_W);
      end
      `OP_RRC_M, `OP_RRC_W: begin
        res = {flags_r[`F_C], m_rd[7:1]};
        new_c = m_rd[0];
        upd_c = 1'b1;
        to_mem = (op_r == `OP_RRC_M);
        to_work = (op_r == `OP_RRC_W);
      end
      `OP_SBC_W, `OP_SBC_M: begin
        res = sbc_full[7:0];
        to_mem = (op_r == `OP_SBC_M);
        to_work = (op_r == `OP_SBC_W);
        upd_z = 1'b1;
        new_c = ~sbc_full[8];
        upd_c = 1'b1;
      end
      default: begin
        res = 8'h00; // idle and unused codes write no result; only pc advances
      end
    endcase
  end

  wire mem_we = ((state_r == S_EXEC) && to_mem) ||
                (do_wr && (aw_addr_r == `OFS_MDATA) && w_strb_r[0]);
  wire [7:0] mem_wd = (state_r == S_EXEC) ? res : w_data_r[7:0];
  wire [AW-1:0] mem_a = busy ? opnd_r[AW-1:0] : maddr_r;

  data_ram #(.AW(AW), .DW(8)) u_ram (
    .clk_i(sys_clk_i),
    .we_i(mem_we),
    .addr_i(mem_a),
    .wdata_i(mem_wd),
    .rdata_o(m_rd)
  );

  // ---------------------------------------------------------------
  // interrupt pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_pending_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // sequencer and architectural state
  // ---------------------------------------------------------------
  // software writes to work_reg/flags/pc only land while idle or halted, since the
  // bus write is held off during an instruction
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      busy_q_r <= 1'b0;
      op_r <= `OP_IDLE;
      opnd_r <= 8'h00;
      tgt_r <= `PC_RST;
      work_reg_r <= 8'h00;
      flags_r <= `FLAGS_RST;
      pc_r <= `PC_RST;
      stack_r <= `PC_RST;
      maddr_r <= {AW{1'b0}};
      watchdog_counter_r <= 8'h00;
      pre_r <= {PRE_W{1'b0}};
      halted_o <= 1'b0;
      irq_service_o <= 1'b0;
    end else begin
      busy_q_r <= busy;
      irq_service_o <= 1'b0;
      if (do_wr) begin
        case (aw_addr_r)
          `OFS_WORK: work_reg_r <= work_mg[7:0];
          `OFS_FLAGS: flags_r <= {1'b0, flags_mg[6:0]};
          `OFS_PC: pc_r <= pc_mg[`PC_W-1:0];
          `OFS_STACK: stack_r <= stack_mg[`PC_W-1:0];
          `OFS_MADDR: maddr_r <= w_data_r[AW-1:0];
          default: ;
        endcase
      end
      // watchdog ticks only while the core clock runs; placed after the
      // bus write so a timeout set in the same edge wins over a flags write
      if (state_r != S_HALT) begin
        pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
        if (&pre_r) begin
          watchdog_counter_r <= watchdog_counter_r + 8'h01;
          if (&watchdog_counter_r) begin
            flags_r[`F_TO] <= 1'b1;
          end
        end
      end
      case (state_r)
        S_IDLE, S_HALT: begin
          if (exec_go) begin
            op_r <= w_data_r[`EX_OP];
            opnd_r <= w_data_r[`EX_OPND];
            tgt_r <= w_data_r[`EX_TGT];
            state_r <= S_FETCH;
            halted_o <= 1'b0;
          end else if ((state_r == S_HALT) && irq_s2_r) begin
            state_r <= S_IDLE; // pending interrupt wakes the core
            halted_o <= 1'b0;
          end
        end
        S_FETCH: begin
          state_r <= S_EXEC; // memory operand arrives next edge
        end
        S_EXEC: begin
          state_r <= S_IDLE;
          pc_r <= pc_r + 12'h001;
          if (to_work) begin
            work_reg_r <= res;
          end
          if (upd_z) begin
            flags_r[`F_Z] <= is_zero(res);
          end
          if (upd_c) begin
            flags_r[`F_C] <= new_c;
          end
          if ((op_r == `OP_SBC_W) || (op_r == `OP_SBC_M)) begin
            flags_r[`F_AC] <= ~sbc_low[4];
            flags_r[`F_OV] <= sbc_ov;
          end
          case (op_r)
            `OP_PDOWN: begin
              watchdog_counter_r <= 8'h00;
              pre_r <= {PRE_W{1'b0}};
              flags_r[`F_SLEEP] <= 1'b1;
              flags_r[`F_TO] <= 1'b0;
              halted_o <= 1'b1;
              state_r <= S_HALT;
            end
            `OP_BRANCH: begin
              pc_r <= tgt_r;
              state_r <= S_DUMMY;
            end
            `OP_SUBX, `OP_SUBX_V: begin
              pc_r <= stack_r;
              state_r <= S_DUMMY;
            end
            `OP_IRQX: begin
              state_r <= S_DUMMY;
              if (irq_s2_r) begin
                // vector at once, return lands on the restored address
                pc_r <= `IRQ_VECTOR;
                flags_r[`F_GATE] <= 1'b0;
                irq_service_o <= 1'b1;
              end else begin
                pc_r <= stack_r;
                flags_r[`F_GATE] <= 1'b1;
              end
            end
            default: ;
          endcase
        end
        S_DUMMY: begin
          state_r <= S_IDLE; // dummy slot while the new address loads
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // readies drop after a take and return with the response handshake, so
  // one write at most is open
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  // memory reads wait one idle cycle so the ram output follows maddr
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
      ar_addr_r <= 8'h00;
      rd_pend_r <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r <= s_axi_araddr;
        rd_pend_r <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (do_rd) begin
        rd_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(ar_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        case (ar_addr_r)
          `OFS_EXEC: s_axi_rdata <= {4'h0, tgt_r, opnd_r, 3'h0, op_r};
          `OFS_WORK: s_axi_rdata <= {24'h0, work_reg_r};
          `OFS_FLAGS: s_axi_rdata <= flags_rd;
          `OFS_PC: s_axi_rdata <= {20'h0, pc_r};
          `OFS_STACK: s_axi_rdata <= {20'h0, stack_r};
          `OFS_MADDR: s_axi_rdata <= {{(32-AW){1'b0}}, maddr_r};
          `OFS_MDATA: s_axi_rdata <= {24'h0, m_rd};
          `OFS_WDOG: s_axi_rdata <= {23'h0, halted_o, watchdog_counter_r};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // exec_unit

// ---- verif/exec_unit_asserts.sv ----
/*
 * port checker for exec_unit: bus handshakes and status pulses.
 * assumes it is bound to exec_unit and sees its port names.
 */
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module exec_unit_asserts (
  input wire sys_clk_i, // clock
  input wire rst_n_i, // reset
  input wire s_axi_awvalid, // aw
  input wire s_axi_awready, // aw
  input wire s_axi_wvalid, // w
  input wire s_axi_wready, // w
  input wire [1:0] s_axi_bresp, // b
  input wire s_axi_bvalid, // b
  input wire s_axi_bready, // b
  input wire s_axi_arvalid, // ar
  input wire s_axi_arready, // ar
  input wire [31:0] s_axi_rdata, // r
  input wire s_axi_rvalid, // r
  input wire s_axi_rready, // r
  input wire halted_o, // halt
  input wire irq_service_o // irq
);
  // ----
  // properties
  // ----
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // answers stand until taken, so a slow master never loses them
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  chk_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("aw taken twice");
  chk_w_blocked: assert property (s_axi_wvalid && s_axi_wready |=>
    !s_axi_wready) else $error("w taken twice");
  chk_ar_blocked: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready) else $error("ar taken twice");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid after handshake");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:10] s_axi_rvalid) else $error("read not answered");
  chk_irq_pulse: assert property (irq_service_o |=> !irq_service_o)
    else $error("irq service not a pulse");
  chk_halt_quiet: assert property (halted_o |-> !irq_service_o)
    else $error("vector while halted");

  cover property (irq_service_o);
  cover property ($rose(halted_o));
  cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // exec_unit_asserts

bind exec_unit exec_unit_asserts u_exec_unit_asserts (.*);

// ---- verif/tb.sv ----
/*
 * self-checking bench for exec_unit: random instructions over AXI4-Lite.
 * assumes exec_unit_defs.vh on the include path and a 100 MHz clock.
 */
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module tb;
  reg sys_clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg irq_pending_i = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, halted_o, irq_service_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_fail = 0, samples_checked = 0, n_irq = 0, i;
  reg [31:0] rnd = 32'h2142394b, q, e;
  reg [11:0] pc, t, s;
  reg [7:0] w, m, x;
  reg [4:0] op;
  reg [3:0] f;

  // short prescaler so the watchdog really counts before power down
  exec_unit #(.PRE_W(2)) u_exec_unit (.*);

  always #5 sys_clk_i = ~sys_clk_i;
  // count vectoring pulses
  always @(posedge sys_clk_i) if (irq_service_o === 1'b1) n_irq <= n_irq + 1;

  // ----
  // helpers
  // ----
  function [31:0] lfsr(input [31:0] v);
    integer j;
    begin
      for (j = 0; j < 32; j++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
      lfsr = v;
    end
  endfunction

  // packs {pc, flags, memory byte, work_reg} after one instruction
  function [31:0] model(input [4:0] op, input [7:0] w, m, x,
      input [3:0] f, input [11:0] t, s, p);
    reg [8:0] d;
    reg c, h, z, v;
    begin
      {v, z, h, c} = f;
      p = p + 12'h001;
      d = {1'b0, w} - {1'b0, m} - !c;
      case (op)
        `OP_INV_M: begin m = ~m; z = m == 0; end
        `OP_INV_W: begin w = ~m; z = w == 0; end
        `OP_DADJ: begin
          d = w + {(w[7:4] > 9 || c) ? 4'h6 : 4'h0,
            (w[3:0] > 9 || h) ? 4'h6 : 4'h0};
          m = d[7:0];
          c = c | d[8];
        end
        `OP_DEC_M: begin m = m - 1; z = m == 0; end
        `OP_DEC_W: begin w = m - 1; z = w == 0; end
        `OP_INC_M: begin m = m + 1; z = m == 0; end
        `OP_INC_W: begin w = m + 1; z = w == 0; end
        `OP_BRANCH: p = t;
        `OP_CP_MW: w = m;
        `OP_CP_IW: w = x;
        `OP_CP_WM: m = w;
        `OP_OR_M: begin w = w | m; z = w == 0; end
        `OP_OR_I: begin w = w | x; z = w == 0; end
        `OP_OR_WB: begin m = w | m; z = m == 0; end
        `OP_SUBX: p = s;
        `OP_SUBX_V: begin p = s; w = x; end
        `OP_RL_M: m = {m[6:0], m[7]};
        `OP_RL_W: w = {m[6:0], m[7]};
        `OP_RLC_M: {c, m} = {m, c};
        `OP_RLC_W: {c, w} = {m, c};
        `OP_RR_M: m = {m[0], m[7:1]};
        `OP_RR_W: w = {m[0], m[7:1]};
        `OP_RRC_M: {m, c} = {c, m};
        `OP_RRC_W: {w, c} = {c, m};
        `OP_SBC_W, `OP_SBC_M: begin
          h = {1'b0, w[3:0]} >= {1'b0, m[3:0]} + !c;
          v = (w[7] ^ m[7]) & (d[7] ^ w[7]);
          c = !d[8];
          z = d[7:0] == 0;
          if (op == `OP_SBC_W) w = d[7:0]; else m = d[7:0];
        end
        default: ;
      endcase
      model = {p, v, z, h, c, m, w};
    end
  endfunction

  task cmp(input [31:0] seen, input [31:0] exp, input string nm);
    begin
      samples_checked++;
      if (seen !== exp) begin
        n_fail++;
        $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // handshakes are sampled mid-cycle, then released right after the edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] er = `RESP_OKAY);
    reg ka, kw, kb;
    reg [1:0] rs;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(negedge sys_clk_i);
        {ka, kw, kb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid,
          s_axi_bresp};
        @(posedge sys_clk_i);
        if (ka) s_axi_awvalid <= 1'b0;
        if (kw) s_axi_wvalid <= 1'b0;
      end while (!kb);
      cmp(rs, er, "bresp");
    end
  endtask

  task rd(input [7:0] a, output [31:0] d, input [1:0] er = `RESP_OKAY);
    reg ka, kr;
    reg [1:0] rs;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(negedge sys_clk_i);
        {ka, kr, rs, d} = {s_axi_arready, s_axi_rvalid, s_axi_rresp,
          s_axi_rdata};
        @(posedge sys_clk_i);
        if (ka) s_axi_arvalid <= 1'b0;
      end while (!kr);
      cmp(rs, er, "rresp");
    end
  endtask

  task results;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // ----
  // sequence
  // ----
  // the whole run needs well under 20k cycles
  initial begin
    #500000;
    n_fail++;
    results;
  end

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd(`OFS_FLAGS, q);
    cmp(q, 32'h0, "flags reset");
    wr(8'h20, 32'h5a, `RESP_SLVERR);
    rd(8'h24, q, `RESP_SLVERR);
    cmp(q, 32'h0, "unmapped");
    // power down, then wake on a pending interrupt
    wr(`OFS_EXEC, `OP_PDOWN);
    rd(`OFS_FLAGS, q);
    cmp(q & 32'h30, 32'h10, "sleep timeout");
    rd(`OFS_WDOG, q);
    cmp(q & 32'h1ff, 32'h100, "watchdog");
    cmp(halted_o, 1, "halted");
    irq_pending_i <= 1'b1;
    for (i = 0; i < 20 && halted_o !== 1'b0; i++) @(posedge sys_clk_i);
    cmp(halted_o, 0, "woken");
    wr(`OFS_EXEC, `OP_IRQX);
    rd(`OFS_PC, q);
    cmp(q, `IRQ_VECTOR, "vector pc");
    cmp(n_irq, 1, "irq pulses");
    irq_pending_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    wr(`OFS_STACK, 32'h2a5);
    wr(`OFS_FLAGS, 32'h0);
    wr(`OFS_EXEC, `OP_IRQX);
    rd(`OFS_PC, q);
    cmp(q, 32'h2a5, "irq exit pc");
    rd(`OFS_FLAGS, q);
    cmp(q & 32'h40, 32'h40, "irq gate");
    pc = 12'h2a5;
    // random instructions; the first four use all-zero and all-one memory bytes
    for (i = 0; i < 150; i++) begin
      rnd = lfsr(rnd);
      {op, w, m, f} = rnd[24:0];
      if (i < 4) m = {8{i[0]}};
      if (op == `OP_PDOWN || op == `OP_IRQX) op = `OP_IDLE;
      rnd = lfsr(rnd);
      {x, t, s} = rnd;
      wr(`OFS_WORK, w);
      wr(`OFS_FLAGS, f);
      wr(`OFS_MADDR, x);
      wr(`OFS_MDATA, m);
      wr(`OFS_STACK, s);
      wr(`OFS_EXEC, {4'h0, t, x, 3'h0, op});
      e = model(op, w, m, x, f, t, s, pc);
      pc = e[31:20];
      rd(`OFS_WORK, q);
      cmp(q & 32'hff, e[7:0], "work");
      rd(`OFS_MDATA, q);
      cmp(q & 32'hff, e[15:8], "mem");
      rd(`OFS_FLAGS, q);
      cmp(q & 32'hf, e[19:16], "flags");
      rd(`OFS_PC, q);
      cmp(q, e[31:20], "pc");
    end
    results;
  end
endmodule // tb
